// [logic/pdt_timer.v]
// two 16-bit timers, pairable into one 32-bit timer, with an APB register file
`timescale 1ns/1ps
`default_nettype none
`include "pdt_consts.vh"
module pdt_timer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        first_ext_clock_pin,
  input  wire        second_ext_clock_pin,
  input  wire        first_gate_pin,
  input  wire        second_gate_pin,
  input  wire        cpu_idle,
  output wire        irq,
  output reg         adc_trigger,
  output reg  [15:0] first_time_base,
  output reg  [15:0] second_time_base
);
  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg  [15:0] ctrl1_reg;
  reg  [15:0] ctrl2_reg;
  reg  [15:0] first_count_reg;
  reg  [15:0] second_count_reg;
  reg  [15:0] first_period_reg;
  reg  [15:0] second_period_reg;
  reg  [3:0]  stat_reg;
  reg  [3:0]  mask_reg;
  reg  [15:0] first_count_next;
  reg  [15:0] second_count_next;
  reg  [3:0]  ev;

  wire        ext1_s;
  wire        ext2_s;
  wire        gate1_s;
  wire        gate2_s;
  wire        idle_s;
  wire        tick1;
  wire        tick2;
  wire        gfall1;
  wire        gfall2;

  wire        wr = psel & penable & pwrite;
  wire        pair_mode_select = ctrl1_reg[`PDT_BIT_PAIR];

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  pdt_sync u_sync_e1 (.pclk(pclk), .presetn(presetn), .d(first_ext_clock_pin), .q(ext1_s));
  pdt_sync u_sync_e2 (.pclk(pclk), .presetn(presetn), .d(second_ext_clock_pin), .q(ext2_s));
  pdt_sync u_sync_g1 (.pclk(pclk), .presetn(presetn), .d(first_gate_pin), .q(gate1_s));
  pdt_sync u_sync_g2 (.pclk(pclk), .presetn(presetn), .d(second_gate_pin), .q(gate2_s));
  pdt_sync u_sync_id (.pclk(pclk), .presetn(presetn), .d(cpu_idle), .q(idle_s));

  // --------------------------------------------------------------------------
  // run enables
  // --------------------------------------------------------------------------
  // paired idle follows the second stop bit, the only live second-word bit
  wire stop1 = idle_s & (pair_mode_select ? ctrl2_reg[`PDT_BIT_SIDL]
                                          : ctrl1_reg[`PDT_BIT_SIDL]);
  wire stop2 = idle_s & ctrl2_reg[`PDT_BIT_SIDL];
  wire run1  = ctrl1_reg[`PDT_BIT_RUN] & ~stop1;
  wire run2  = ~pair_mode_select & ctrl2_reg[`PDT_BIT_RUN] & ~stop2;

  // both timers are synchronous counters; no asynchronous mode exists
  pdt_tick u_tick1
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (run1),
    .clk_src   (ctrl1_reg[`PDT_BIT_CS]),
    .gate_en   (ctrl1_reg[`PDT_BIT_GATE]),
    .prescale  (ctrl1_reg[`PDT_BIT_PS_HI:`PDT_BIT_PS_LO]),
    .ext_clk   (ext1_s),
    .gate_in   (gate1_s),
    .tick      (tick1),
    .gate_fall (gfall1)
  );

  pdt_tick u_tick2
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (run2),
    .clk_src   (ctrl2_reg[`PDT_BIT_CS]),
    .gate_en   (ctrl2_reg[`PDT_BIT_GATE]),
    .prescale  (ctrl2_reg[`PDT_BIT_PS_HI:`PDT_BIT_PS_LO]),
    .ext_clk   (ext2_s),
    .gate_in   (gate2_s),
    .tick      (tick2),
    .gate_fall (gfall2)
  );

  // --------------------------------------------------------------------------
  // counters
  // --------------------------------------------------------------------------
  wire [31:0] count32  = {second_count_reg, first_count_reg};
  wire [31:0] period32 = {second_period_reg, first_period_reg};
  wire        match32  = pair_mode_select & tick1 & (count32 == period32);
  wire        match1   = ~pair_mode_select & tick1 & (first_count_reg == first_period_reg);
  wire        match2   = tick2 & (second_count_reg == second_period_reg);
  wire [31:0] inc32    = count32 + 32'h0000_0001;

  always @*
  begin
    first_count_next  = first_count_reg;
    second_count_next = second_count_reg;
    if (pair_mode_select)
    begin
      if (tick1)
      begin
        // wrap to zero on the tick after reaching the period
        first_count_next  = match32 ? 16'h0000 : inc32[15:0];
        second_count_next = match32 ? 16'h0000 : inc32[31:16];
      end
    end
    else
    begin
      if (tick1)
        first_count_next = match1 ? 16'h0000 : first_count_reg + 16'h0001;
      if (tick2)
        second_count_next = match2 ? 16'h0000 : second_count_reg + 16'h0001;
    end
    // a software write to a count wins over a tick
    if (wr && paddr == `PDT_OFS_CNT1)
      first_count_next = pwdata[15:0];
    if (wr && paddr == `PDT_OFS_CNT2)
      second_count_next = pwdata[15:0];
  end

  // --------------------------------------------------------------------------
  // events: bit0 first match, bit1 second match, bit2/3 gate falling edges
  // --------------------------------------------------------------------------
  always @*
  begin
    ev    = 4'h0;
    ev[0] = match1;
    ev[1] = match2 | match32;
    ev[2] = gfall1;
    ev[3] = gfall2 & ~pair_mode_select;
  end

  assign irq     = |(stat_reg & mask_reg);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_reg         <= `PDT_CTRL_RESET;
      ctrl2_reg         <= `PDT_CTRL_RESET;
      first_count_reg   <= 16'h0000;
      second_count_reg  <= 16'h0000;
      first_period_reg  <= `PDT_PER_RESET;
      second_period_reg <= `PDT_PER_RESET;
      stat_reg          <= 4'h0;
      mask_reg          <= 4'h0;
      adc_trigger       <= 1'b0;
      first_time_base   <= 16'h0000;
      second_time_base  <= 16'h0000;
    end
    else
    begin
      first_count_reg  <= first_count_next;
      second_count_reg <= second_count_next;
      adc_trigger      <= match32;
      first_time_base  <= first_count_next;
      second_time_base <= second_count_next;
      // set wins over a write-one clear in the same cycle
      if (wr && paddr == `PDT_OFS_STAT)
        stat_reg <= (stat_reg & ~pwdata[3:0]) | ev;
      else
        stat_reg <= stat_reg | ev;
      if (wr)
      begin
        case (paddr)
          `PDT_OFS_CTRL1: ctrl1_reg         <= pwdata[15:0] & `PDT_CTRL1_MASK;
          `PDT_OFS_CTRL2: ctrl2_reg         <= pwdata[15:0] & `PDT_CTRL2_MASK;
          `PDT_OFS_PER1:  first_period_reg  <= pwdata[15:0];
          `PDT_OFS_PER2:  second_period_reg <= pwdata[15:0];
          `PDT_OFS_MASK:  mask_reg          <= pwdata[3:0];
          default:        ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  always @*
  begin
    case (paddr)
      `PDT_OFS_CTRL1: prdata = {16'h0000, ctrl1_reg};
      `PDT_OFS_CTRL2: prdata = {16'h0000, ctrl2_reg};
      `PDT_OFS_CNT1:  prdata = {16'h0000, first_count_reg};
      `PDT_OFS_CNT2:  prdata = {16'h0000, second_count_reg};
      `PDT_OFS_PER1:  prdata = {16'h0000, first_period_reg};
      `PDT_OFS_PER2:  prdata = {16'h0000, second_period_reg};
      `PDT_OFS_STAT:  prdata = {28'h0000000, stat_reg};
      `PDT_OFS_MASK:  prdata = {28'h0000000, mask_reg};
      `PDT_OFS_IDLE:  prdata = {31'h00000000, idle_s};
      default:        prdata = 32'h0000_0000;
    endcase
  end
endmodule // pdt_timer
`default_nettype wire

// [logic/pdt_consts.vh]
// constants for the pairable dual 16-bit timer
// Notes on behaviour
// - pair bit joins timers into 32 bits
// - first count low word, second high
// - paired: second control word ignored except its stop bit
// - paired match flags second timer interrupt
// - paired period: second high, first low
// - first run bit starts or stops counting
// - stop-in-idle halts timer during idle
// - paired idle governed by second stop bit
// - gate honoured only with internal clock
// - prescale 1, 8, 64 or 256
// - first source bit picks external rising edges
// - second source bit picks its pin
// - independent timers, synchronous modes only
// - adc trigger only from paired match
// - both counts offered as time bases
// - unimplemented bits read zero, reset zero
`ifndef PDT_CONSTS_VH
`define PDT_CONSTS_VH
`define PDT_OFS_CTRL1   12'h000
`define PDT_OFS_CTRL2   12'h004
`define PDT_OFS_CNT1    12'h008
`define PDT_OFS_CNT2    12'h00C
`define PDT_OFS_PER1    12'h010
`define PDT_OFS_PER2    12'h014
`define PDT_OFS_STAT    12'h018
`define PDT_OFS_MASK    12'h01C
`define PDT_OFS_IDLE    12'h020
`define PDT_BIT_RUN     15
`define PDT_BIT_SIDL    13
`define PDT_BIT_GATE    6
`define PDT_BIT_PS_HI   5
`define PDT_BIT_PS_LO   4
`define PDT_BIT_PAIR    3
`define PDT_BIT_CS      1
`define PDT_CTRL1_MASK  16'hA07A
`define PDT_CTRL2_MASK  16'hA072
`define PDT_CTRL_RESET  16'h0000
`define PDT_PER_RESET   16'hFFFF
`define PDT_DIV_1       8'h00
`define PDT_DIV_8       8'h07
`define PDT_DIV_64      8'h3F
`define PDT_DIV_256     8'hFF
`endif

// [logic/pdt_sync.v]
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module pdt_sync
(
  input  wire pclk,
  input  wire presetn,
  input  wire d,
  output wire q
);
  reg s1_reg;
  reg s2_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule // pdt_sync
`default_nettype wire

// [logic/pdt_tick.v]
// clock selection, gating and prescaler for one timer
`timescale 1ns/1ps
`default_nettype none
`include "pdt_consts.vh"
module pdt_tick
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       enable,
  input  wire       clk_src,
  input  wire       gate_en,
  input  wire [1:0] prescale,
  input  wire       ext_clk,
  input  wire       gate_in,
  output wire       tick,
  output wire       gate_fall
);
  reg       ext_d_reg;
  reg       gate_d_reg;
  reg [7:0] pre_reg;
  reg [7:0] lim;
  wire      ext_rise;
  wire      src_pulse;
  always @*
  begin
    case (prescale)
      2'b00:   lim = `PDT_DIV_1;
      2'b01:   lim = `PDT_DIV_8;
      2'b10:   lim = `PDT_DIV_64;
      default: lim = `PDT_DIV_256;
    endcase
  end
  assign ext_rise  = ext_clk & ~ext_d_reg;
  assign gate_fall = enable & ~clk_src & gate_en & gate_d_reg & ~gate_in;
  // gate only with internal clock; external counts rising edges
  assign src_pulse = enable & (clk_src ? ext_rise : (~gate_en | gate_in));
  assign tick      = src_pulse & (pre_reg == lim);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_d_reg  <= 1'b0;
      gate_d_reg <= 1'b0;
      pre_reg    <= 8'h00;
    end
    else
    begin
      ext_d_reg  <= ext_clk;
      gate_d_reg <= gate_in;
      if (!enable)
        pre_reg <= 8'h00;
      else if (src_pulse)
        pre_reg <= (pre_reg == lim) ? 8'h00 : pre_reg + 8'h01;
    end
  end
endmodule // pdt_tick
`default_nettype wire

// [testbench/pdt_timer_assertions.sv]
// concurrent checks on the pairable dual timer ports
`timescale 1ns/1ps
`default_nettype none
`include "pdt_consts.vh"
module pdt_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        adc_trigger
);
  // --------------------------------
  // shadow of pair bit and mask bit
  // --------------------------------
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite;
  reg  pair_reg;
  reg  msk_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pair_reg <= 1'b0;
      msk_reg  <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `PDT_OFS_CTRL1)
        pair_reg <= pwdata[3];
      if (wr && paddr == `PDT_OFS_MASK)
        msk_reg <= pwdata[1];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ctrl1_spare: assert property (rd && paddr == `PDT_OFS_CTRL1 |-> (prdata & 32'hFFFF5F85) == 32'h0)
    else $error("ctrl1 spare bits set");
  a_ctrl2_spare: assert property (rd && paddr == `PDT_OFS_CTRL2 |-> (prdata & 32'hFFFF5F8D) == 32'h0)
    else $error("ctrl2 spare bits set");
  a_unmapped_zero: assert property (rd && paddr > 12'h020 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_idle_spare: assert property (rd && paddr == `PDT_OFS_IDLE |-> prdata[31:1] == 31'h0)
    else $error("idle spare bits set");
  a_bus_ready: assert property (psel |-> pready && !pslverr)
    else $error("bus answer wrong");
  a_mask_quiet: assert property (wr && paddr == `PDT_OFS_MASK && pwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq with all masked");
  a_trig_paired: assert property (adc_trigger |-> pair_reg || $past(pair_reg))
    else $error("trigger while unpaired");
  a_trig_flag: assert property (adc_trigger && msk_reg |-> irq)
    else $error("paired match without irq");
  c_trig: cover property (adc_trigger);
  c_irq: cover property (irq);
  c_ctrl_rd: cover property (rd && paddr == `PDT_OFS_CTRL1);
endmodule // pdt_chk
bind pdt_timer pdt_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .adc_trigger(adc_trigger));
`default_nettype wire

// [testbench/tb_top.sv]
// register-level bench for the pairable dual timer
`timescale 1ns/1ps
`default_nettype none
`include "pdt_consts.vh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, ec1, g1, idle;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, adc_trigger;
  wire  [15:0] tb1, tb2;
  int          err_count, cmp_count, c, i, trig;
  int          dv [4] = '{1, 8, 64, 256};
  pdt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_ext_clock_pin(ec1), .second_ext_clock_pin(1'b0), .first_gate_pin(g1),
    .second_gate_pin(1'b0), .cpu_idle(idle), .irq(irq), .adc_trigger(adc_trigger),
    .first_time_base(tb1), .second_time_base(tb2));
  // ----------
  // tasks
  // ----------
  task automatic close_out();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_count++;
      close_out();
    end
    rdat = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  // cycles between two entries of a time base into zero
  task automatic gap(input logic s, output int n);
    int k;
    int t;
    k = 0;
    n = 0;
    t = 0;
    while (k < 4)
    begin
      @(posedge pclk);
      n++;
      t++;
      trig += (adc_trigger === 1'b1);
      if (((s ? tb2 : tb1) == 16'h0) == k[0])
      begin
        k++;
        if (k == 2)
          n = 0;
      end
      if (t >= 2000)
      begin
        err_count++;
        close_out();
      end
    end
  endtask
  task automatic wt(input logic [15:0] v, output int n);
    n = 0;
    while (tb2 !== v)
    begin
      @(posedge pclk);
      n++;
      if (n >= 100)
      begin
        err_count++;
        close_out();
      end
    end
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, ec1, g1, idle} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rc(`PDT_OFS_CTRL2, 32'h0, "ctrl2");
    rc(`PDT_OFS_CNT1, 32'h0, "cnt1");
    wr(`PDT_OFS_CTRL1, 32'hFFFFFFFF);
    rc(`PDT_OFS_CTRL1, 32'h0000A07A, "ctrl1 bits");
    wr(`PDT_OFS_CTRL2, 32'hFFFFFFFF);
    rc(`PDT_OFS_CTRL2, 32'h0000A072, "ctrl2 bits");
    wr(`PDT_OFS_CTRL2, 32'h0);
    wr(12'h024, 32'hFFFFFFFF);
    rc(12'h024, 32'h0, "unmapped");
    wr(`PDT_OFS_PER1, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      wr(`PDT_OFS_CTRL1, 32'h8000 | (i << 4));
      gap(1'b0, c);
      chk("gap16", 2 * dv[i], c);
    end
    wr(`PDT_OFS_CTRL1, 32'h0);
    apb(1'b0, `PDT_OFS_CNT1, 32'h0);
    c = rdat;
    rc(`PDT_OFS_CNT1, c, "stopped");
    rc(`PDT_OFS_STAT, 32'h1, "stat16");
    wr(`PDT_OFS_MASK, 32'h1);
    @(posedge pclk);
    chk("irq on", 1, irq);
    wr(`PDT_OFS_STAT, 32'h1);
    @(posedge pclk);
    chk("irq off", 0, irq);
    wr(`PDT_OFS_PER2, 32'h2);
    wr(`PDT_OFS_CTRL2, 32'h8000);
    gap(1'b1, c);
    chk("gap2", 3, c);
    wr(`PDT_OFS_CTRL1, 32'h0008);
    wr(`PDT_OFS_PER1, 32'h3);
    wr(`PDT_OFS_PER2, 32'h0);
    wr(`PDT_OFS_CNT2, 32'h0);
    // second word asks for 1:256; paired mode must not honour it
    wr(`PDT_OFS_CTRL2, 32'h8030);
    // cleared once pairing has stopped the second timer's own matches
    wr(`PDT_OFS_STAT, 32'hF);
    wr(`PDT_OFS_MASK, 32'h2);
    wr(`PDT_OFS_CTRL1, 32'h8008);
    trig = 0;
    gap(1'b0, c);
    chk("gap32", 4, c);
    chk("high word", 0, tb2);
    chk("trigger", 1, trig > 0);
    wr(`PDT_OFS_CTRL1, 32'h0008);
    rc(`PDT_OFS_STAT, 32'h2, "stat32");
    chk("irq32", 1, irq);
    wr(`PDT_OFS_PER2, 32'h1);
    wr(`PDT_OFS_CNT1, 32'hFFFE);
    wr(`PDT_OFS_CTRL1, 32'h8008);
    wt(16'h1, c);
    wt(16'h0, c);
    chk("wrap32", 4, c);
    wr(`PDT_OFS_CTRL2, 32'h2000);
    idle <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, `PDT_OFS_CNT1, 32'h0);
    c = rdat;
    rc(`PDT_OFS_CNT1, c, "idle halt");
    wr(`PDT_OFS_CTRL2, 32'h0);
    apb(1'b0, `PDT_OFS_CNT1, 32'h0);
    chk("idle run", 1, rdat != c);
    wr(`PDT_OFS_CTRL1, 32'hA000);
    apb(1'b0, `PDT_OFS_CNT1, 32'h0);
    c = rdat;
    rc(`PDT_OFS_CNT1, c, "idle16");
    idle <= 1'b0;
    wr(`PDT_OFS_CTRL1, 32'h0);
    wr(`PDT_OFS_PER1, 32'hFFFF);
    wr(`PDT_OFS_CNT1, 32'h0);
    wr(`PDT_OFS_CTRL1, 32'h8002);
    repeat (10)
    begin
      repeat (4) @(posedge pclk);
      ec1 <= ~ec1;
    end
    repeat (8) @(posedge pclk);
    rc(`PDT_OFS_CNT1, 32'h5, "ext edges");
    wr(`PDT_OFS_CTRL1, 32'h0);
    wr(`PDT_OFS_CNT1, 32'h0);
    wr(`PDT_OFS_CTRL1, 32'h8040);
    rc(`PDT_OFS_CNT1, 32'h0, "gate low");
    g1 <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, `PDT_OFS_CNT1, 32'h0);
    chk("gate high", 1, rdat != 0);
    wr(`PDT_OFS_STAT, 32'hF);
    wr(`PDT_OFS_MASK, 32'h4);
    g1 <= 1'b0;
    repeat (4) @(posedge pclk);
    rc(`PDT_OFS_STAT, 32'h4, "gate fall");
    chk("irq gate", 1, irq);
    wr(`PDT_OFS_MASK, 32'h0);
    @(posedge pclk);
    chk("irq masked", 0, irq);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
